// >>> rtl/cfdt_chan.sv
`timescale 1ns/10ps
`include "cfdt_consts.svh"

// one qualification timer: counts ticks while the comparator holds
module cfdt_chan #(
    parameter int CNT_W = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             tick,
    input  wire logic             cond,
    input  wire logic [CNT_W-1:0] limit,
    output logic                  fault
);

    cfdt_pkg::cfdt_chan_state_t st;
    cfdt_pkg::cfdt_chan_state_t next_st;

    always_comb begin
        next_st = st;
        if (!cond) begin
            next_st.cnt = '0;                                   // [RQ9]
        end else if (tick && (st.cnt < 16'(limit))) begin
            next_st.cnt = st.cnt + 16'h0001;
        end
        next_st.fault = cond && (st.cnt >= 16'(limit));        // [RQ1]
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign fault = st.fault;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_restart_on_clear: assert property (       // [RQ9]
        !cond |=> (st.cnt == 16'h0000) && !st.fault)
        else $error("timer did not restart when condition cleared");

    chk_fault_after_limit: assert property (      // [RQ1]
        $rose(st.fault) |-> $past(cond) && ($past(st.cnt) >= $past(16'(limit))))
        else $error("fault declared before delay elapsed");

    chk_zero_delay_detect: assert property (      // [RQ6]
        (cond && (limit == '0)) |=> st.fault)
        else $error("zero delay fault not recognised next cycle");

endmodule : cfdt_chan

// >>> rtl/cfdt_consts.svh
`ifndef CFDT_CONSTS_SVH
`define CFDT_CONSTS_SVH

// register byte addresses
`define CFDT_ADDR_CTRL        8'h00
`define CFDT_ADDR_DELAY       8'h04
`define CFDT_ADDR_STATUS      8'h08
`define CFDT_ADDR_MASK        8'h0C
`define CFDT_ADDR_FAULT       8'h10
`define CFDT_ADDR_STEP        8'h14

// field positions
`define CFDT_CTRL_DOUBLING    0
`define CFDT_CTRL_SCALING     1
`define CFDT_DLY_DOVC_LSB     0
`define CFDT_DLY_CSHORT_LSB   4
`define CFDT_DLY_DSHORT1_LSB  8
`define CFDT_DLY_DSHORT2_LSB  12

// reset values
`define CFDT_CTRL_RESET       2'h2
`define CFDT_DELAY_RESET      16'h0000
`define CFDT_MASK_RESET       4'h0

// timing
`define CFDT_CLK_PERIOD_NS    10
`define CFDT_TICK_NS          500
`define CFDT_TICK_CYCLES      (`CFDT_TICK_NS / `CFDT_CLK_PERIOD_NS)
`define CFDT_DOVC_BASE_NS     1000000
`define CFDT_DOVC_STEP_NS     2000000
`define CFDT_CSHORT_STEP_NS   61000
`define CFDT_DSHORT1_STEP_NS  61000
`define CFDT_DSHORT1_STEP2_NS 121000
`define CFDT_DSHORT2_STEP_NS  30500
`define CFDT_DSHORT2_STEP2_NS 61000
`define CFDT_DETECT_NS        160000
`define CFDT_DETECT_CYCLES    (`CFDT_DETECT_NS / `CFDT_CLK_PERIOD_NS)

// discharge overcurrent threshold step, microvolt magnitude
`define CFDT_DOVC_STEP_HI_UV  16'h15B8
`define CFDT_DOVC_STEP_LO_UV  16'h0ADC

`endif

// >>> rtl/cfdt_pkg.sv
package cfdt_pkg;

    typedef enum logic [1:0] {
        CFDT_CH_DOVC,
        CFDT_CH_CSHORT,
        CFDT_CH_DSHORT1,
        CFDT_CH_DSHORT2
    } cfdt_chan_t;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } cfdt_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } cfdt_axi_rsp_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic        fault;
    } cfdt_chan_state_t;

    typedef struct packed {
        cfdt_axi_rsp_t rsp;
        logic          aw_held;
        logic          w_held;
        logic [7:0]    awaddr;
        logic [31:0]   wdata;
        logic [3:0]    wstrb;
        logic [1:0]    ctrl;
        logic [15:0]   delay;
        logic [3:0]    status;
        logic [3:0]    mask;
        logic [3:0]    fault_prev;
        logic          irq;
        logic [7:0]    tick_cnt;
        logic          tick;
    } cfdt_top_state_t;

endpackage : cfdt_pkg

// >>> rtl/cfdt_top.sv
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "cfdt_consts.svh"

// Overview of operation
// RQ1: discharge overcurrent delay 1 to 31 ms in 2 ms steps, then fault.
// RQ2: charge short circuit delay 0 to 915 us in 61 us steps.
// RQ3: first discharge short delay 61 us steps, or 121 us when doubled.
// RQ4: second discharge short delay 30.5 us steps, or 61 us when doubled.
// RQ5: one doubling bit scales both discharge short timers; 1 means doubled.
// RQ6: fault recognised within 160 us after comparator trips.
// RQ7: longest delay setting within ten percent of programmed value.
// RQ8: scaling bit clear halves threshold steps: 5.56 mV versus 2.78 mV.
// RQ9: timer counts only while condition holds, restarts when it clears.
module cfdt_top #(
    parameter int CNT_W       = 16,
    parameter int CODE_W      = 4,
    parameter int TICK_CYCLES = `CFDT_TICK_CYCLES
) (
    input  wire logic                   SYS_CLK,
    input  wire logic                   RST_N,
    input  wire cfdt_pkg::cfdt_axi_req_t AXI_REQ,
    output cfdt_pkg::cfdt_axi_rsp_t     AXI_RSP,
    input  wire logic [3:0]             FAULT_COND,
    output logic [3:0]                  FAULT,
    output logic                        SHORT_DELAY_DOUBLING,
    output logic                        SENSE_SCALING_SELECT,
    output logic                        IRQ
);

    localparam int DOVC_BASE    = `CFDT_DOVC_BASE_NS / `CFDT_TICK_NS;
    localparam int DOVC_STEP    = `CFDT_DOVC_STEP_NS / `CFDT_TICK_NS;
    localparam int CSHORT_STEP  = `CFDT_CSHORT_STEP_NS / `CFDT_TICK_NS;
    localparam int DSHORT1_STEP = `CFDT_DSHORT1_STEP_NS / `CFDT_TICK_NS;
    localparam int DSHORT1_DBL  = `CFDT_DSHORT1_STEP2_NS / `CFDT_TICK_NS;
    localparam int DSHORT2_STEP = `CFDT_DSHORT2_STEP_NS / `CFDT_TICK_NS;
    localparam int DSHORT2_DBL  = `CFDT_DSHORT2_STEP2_NS / `CFDT_TICK_NS;
    localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    cfdt_pkg::cfdt_top_state_t st;
    cfdt_pkg::cfdt_top_state_t next_st;
    logic [3:0]                fault_live;
    logic [CNT_W-1:0]          limit [4];
    logic [CODE_W-1:0]         code_dovc;
    logic [CODE_W-1:0]         code_cshort;
    logic [CODE_W-1:0]         code_dshort1;
    logic [CODE_W-1:0]         code_dshort2;
    logic                      doubling;

    assign doubling     = st.ctrl[`CFDT_CTRL_DOUBLING];
    assign code_dovc    = st.delay[`CFDT_DLY_DOVC_LSB +: CODE_W];
    assign code_cshort  = st.delay[`CFDT_DLY_CSHORT_LSB +: CODE_W];
    assign code_dshort1 = st.delay[`CFDT_DLY_DSHORT1_LSB +: CODE_W];
    assign code_dshort2 = st.delay[`CFDT_DLY_DSHORT2_LSB +: CODE_W];

    // delay limits in timer ticks
    always_comb begin
        limit[cfdt_pkg::CFDT_CH_DOVC] =
            CNT_W'(DOVC_BASE + int'(code_dovc) * DOVC_STEP);     // [RQ1]
        limit[cfdt_pkg::CFDT_CH_CSHORT] =
            CNT_W'(int'(code_cshort) * CSHORT_STEP);             // [RQ2]
        limit[cfdt_pkg::CFDT_CH_DSHORT1] = doubling ?            // [RQ5]
            CNT_W'(int'(code_dshort1) * DSHORT1_DBL) :
            CNT_W'(int'(code_dshort1) * DSHORT1_STEP);           // [RQ3]
        limit[cfdt_pkg::CFDT_CH_DSHORT2] = doubling ?            // [RQ5]
            CNT_W'(int'(code_dshort2) * DSHORT2_DBL) :
            CNT_W'(int'(code_dshort2) * DSHORT2_STEP);           // [RQ4]
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_chan
            cfdt_chan #(
                .CNT_W (CNT_W)
            ) u_chan (
                .clk   (SYS_CLK),
                .rst_n (RST_N),
                .tick  (st.tick),
                .cond  (FAULT_COND[gi]),
                .limit (limit[gi]),
                .fault (fault_live[gi])
            );
        end
    endgenerate

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return res;
    endfunction : merge

    function automatic logic is_mapped(input logic [7:0] a);
        return (a == `CFDT_ADDR_CTRL) || (a == `CFDT_ADDR_DELAY) ||
               (a == `CFDT_ADDR_STATUS) || (a == `CFDT_ADDR_MASK) ||
               (a == `CFDT_ADDR_FAULT) || (a == `CFDT_ADDR_STEP);
    endfunction : is_mapped

    logic [3:0]  fault_rise;
    logic [3:0]  status_clear;
    logic [31:0] rd_word;
    logic [31:0] wr_word;
    logic [15:0] thr_step_uv;

    always_comb begin
        next_st      = st;
        fault_rise   = fault_live & ~st.fault_prev;             // [RQ6]
        status_clear = 4'h0;
        rd_word      = 32'h0000_0000;
        wr_word      = 32'h0000_0000;
        thr_step_uv  = st.ctrl[`CFDT_CTRL_SCALING] ?
                       `CFDT_DOVC_STEP_HI_UV : `CFDT_DOVC_STEP_LO_UV; // [RQ8]

        // one-cycle tick every 500 ns, sets timer resolution
        if (st.tick_cnt == TICK_LAST) begin                     // [RQ7]
            next_st.tick_cnt = 8'h00;
            next_st.tick     = 1'b1;
        end else begin
            next_st.tick_cnt = st.tick_cnt + 8'h01;
            next_st.tick     = 1'b0;
        end

        // write address and data, either order
        if (AXI_REQ.awvalid && st.rsp.awready) begin
            next_st.aw_held = 1'b1;
            next_st.awaddr  = AXI_REQ.awaddr;
        end
        if (AXI_REQ.wvalid && st.rsp.wready) begin
            next_st.w_held = 1'b1;
            next_st.wdata  = AXI_REQ.wdata;
            next_st.wstrb  = AXI_REQ.wstrb;
        end
        if (st.rsp.bvalid && AXI_REQ.bready) begin
            next_st.rsp.bvalid = 1'b0;
        end
        if (st.aw_held && st.w_held && !st.rsp.bvalid) begin
            next_st.aw_held    = 1'b0;
            next_st.w_held     = 1'b0;
            next_st.rsp.bvalid = 1'b1;
            next_st.rsp.bresp  = is_mapped(st.awaddr) ? RESP_OK : RESP_ERR;
            case (st.awaddr)
                `CFDT_ADDR_CTRL: begin
                    wr_word = merge({30'h0, st.ctrl}, st.wdata, st.wstrb);
                    next_st.ctrl = wr_word[1:0];                 // [RQ5]
                end
                `CFDT_ADDR_DELAY: begin
                    wr_word = merge({16'h0, st.delay}, st.wdata, st.wstrb);
                    next_st.delay = wr_word[15:0];
                end
                `CFDT_ADDR_MASK: begin
                    wr_word = merge({28'h0, st.mask}, st.wdata, st.wstrb);
                    next_st.mask = wr_word[3:0];
                end
                default: begin
                    wr_word = 32'h0000_0000;
                end
            endcase
        end
        next_st.rsp.awready = !next_st.aw_held && !next_st.rsp.bvalid;
        next_st.rsp.wready  = !next_st.w_held && !next_st.rsp.bvalid;

        // read channel
        if (st.rsp.rvalid && AXI_REQ.rready) begin
            next_st.rsp.rvalid  = 1'b0;
            next_st.rsp.arready = 1'b1;
        end
        if (AXI_REQ.arvalid && st.rsp.arready) begin
            case (AXI_REQ.araddr)
                `CFDT_ADDR_CTRL:   rd_word = {30'h0, st.ctrl};
                `CFDT_ADDR_DELAY:  rd_word = {16'h0, st.delay};
                `CFDT_ADDR_STATUS: begin
                    rd_word      = {28'h0, st.status};
                    status_clear = 4'hF;
                end
                `CFDT_ADDR_MASK:   rd_word = {28'h0, st.mask};
                `CFDT_ADDR_FAULT:  rd_word = {28'h0, fault_live};
                `CFDT_ADDR_STEP:   rd_word = {16'h0, thr_step_uv};
                default:           rd_word = 32'h0000_0000;
            endcase
            next_st.rsp.rdata   = rd_word;
            next_st.rsp.rresp   = is_mapped(AXI_REQ.araddr) ? RESP_OK
                                                             : RESP_ERR;
            next_st.rsp.rvalid  = 1'b1;
            next_st.rsp.arready = 1'b0;
        end

        // sticky events; a new event wins over the read clear
        next_st.status     = (st.status & ~status_clear) | fault_rise;
        next_st.fault_prev = fault_live;
        next_st.irq        = |(next_st.status & next_st.mask);
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            st             <= '0;
            st.ctrl        <= `CFDT_CTRL_RESET;
            st.delay       <= `CFDT_DELAY_RESET;
            st.mask        <= `CFDT_MASK_RESET;
            st.rsp.awready <= 1'b1;
            st.rsp.wready  <= 1'b1;
            st.rsp.arready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign AXI_RSP              = st.rsp;
    assign FAULT                = st.fault_prev;
    assign SHORT_DELAY_DOUBLING = st.ctrl[`CFDT_CTRL_DOUBLING];
    assign SENSE_SCALING_SELECT = st.ctrl[`CFDT_CTRL_SCALING];
    assign IRQ                  = st.irq;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    chk_dovc_range: assert property (             // [RQ1]
        limit[0] == CNT_W'(2000 + 4000 * int'(code_dovc)))
        else $error("overcurrent delay not 1 ms plus 2 ms steps");

    chk_cshort_step: assert property (            // [RQ2]
        (code_cshort == 4'hF) |-> (limit[1] == 16'h0726))
        else $error("charge short longest delay not 915 us");

    chk_short_doubling: assert property (         // [RQ5]
        $changed(doubling) && (code_dshort1 != 4'h0) &&
            (code_dshort2 != 4'h0) |->
            (limit[2] != $past(limit[2])) && (limit[3] != $past(limit[3])))
        else $error("doubling bit did not scale both short timers");

    chk_dshort1_step: assert property (           // [RQ3]
        (code_dshort1 == 4'h1) |->
            limit[2] == (doubling ? 16'h00F2 : 16'h007A))
        else $error("first discharge short step wrong");

    chk_dshort2_step: assert property (           // [RQ4]
        (code_dshort2 == 4'h1) |->
            limit[3] == (doubling ? 16'h007A : 16'h003D))
        else $error("second discharge short step wrong");

    chk_tick_period: assert property (            // [RQ7]
        st.tick |-> ##TICK_CYCLES st.tick)
        else $error("timer tick period wrong");

    chk_fault_to_status: assert property (        // [RQ6]
        $rose(FAULT[0]) |-> st.status[0] && (IRQ || !st.mask[0]))
        else $error("fault event not latched");

    chk_step_select: assert property (            // [RQ8]
        thr_step_uv == (SENSE_SCALING_SELECT ? 16'h15B8 : 16'h0ADC))
        else $error("threshold step not tied to scaling bit");

    chk_rvalid_hold: assert property (
        st.rsp.rvalid && !AXI_REQ.rready |=>
            st.rsp.rvalid && $stable(st.rsp.rdata))
        else $error("read data dropped before taken");

    chk_status_sticky: assert property (          // [RQ6]
        !(AXI_REQ.arvalid && st.rsp.arready &&
          AXI_REQ.araddr == `CFDT_ADDR_STATUS) |=>
            ((st.status & $past(st.status)) == $past(st.status)))
        else $error("status event lost without a read");

    chk_fault_drop: assert property (             // [RQ9]
        (FAULT_COND == 4'h0) ##1 (FAULT_COND == 4'h0) |=>
            (FAULT == 4'h0))
        else $error("fault held after condition cleared");

    chk_fault_needs_cond: assert property (       // [RQ9]
        (FAULT != 4'h0) |->
            ((FAULT & $past(FAULT_COND, 2)) == FAULT))
        else $error("fault shown without its condition");

    // bus handshake and unmapped read error response checks
    chk_bvalid_hold: assert property (
        st.rsp.bvalid && !AXI_REQ.bready |=>
            st.rsp.bvalid && $stable(st.rsp.bresp))
        else $error("write response dropped before taken");

    chk_arready_refuse: assert property (
        st.rsp.rvalid |-> !st.rsp.arready)
        else $error("read address accepted while data pending");

    chk_unmapped_read: assert property (
        AXI_REQ.arvalid && st.rsp.arready &&
            !is_mapped(AXI_REQ.araddr) |=>
            (st.rsp.rresp == RESP_ERR) &&
            (st.rsp.rdata == 32'h0000_0000))
        else $error("unmapped read not answered with error");

    cov_dovc_fault: cover property ($rose(FAULT[0]));
    cov_doubled_fault: cover property (doubling && $rose(FAULT[2]));
    cov_irq_raise: cover property ($rose(IRQ));
    cov_status_read: cover property (
        AXI_REQ.arvalid && st.rsp.arready &&
        AXI_REQ.araddr == `CFDT_ADDR_STATUS && st.status != 4'h0);

endmodule : cfdt_top

// >>> testbench/cfdt_sense_model.sv
`timescale 1ns/10ps

// comparator front end: trip requests become conditions, fault lag logged
module cfdt_sense_model (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [3:0]       trip,
    input  wire logic [3:0]       fault,
    output logic      [3:0]       cond,
    output logic      [3:0][31:0] lag
);
    logic [3:0][31:0] cnt;
    logic [3:0]       fault_q;

    // lag is cycles from condition rise to fault rise, from the latest rise
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cond    <= 4'h0;
            cnt     <= '0;
            fault_q <= 4'h0;
            lag     <= '0;
        end else begin
            cond    <= trip;
            fault_q <= fault;
            for (int i = 0; i < 4; i++) begin
                cnt[i] <= cond[i] ? cnt[i] + 32'h1 : 32'h0;
                if (fault[i] && !fault_q[i]) begin
                    lag[i] <= cnt[i];
                end
            end
        end
    end
endmodule : cfdt_sense_model

// >>> testbench/cfdt_top_tb.sv
`timescale 1ns/10ps
`include "cfdt_consts.svh"

module cfdt_top_tb;
    localparam int TK = `CFDT_TICK_NS;
    localparam int TB_TICK = 5;
    logic                    clk;
    logic                    rst_n;
    cfdt_pkg::cfdt_axi_req_t req;
    cfdt_pkg::cfdt_axi_rsp_t rsp;
    logic [3:0]              trip;
    logic [3:0]              cond;
    logic [3:0]              fault;
    logic                    dbl;
    logic                    scl;
    logic                    irq;
    logic [3:0][31:0]        lag;
    int                      fail_count = 0;
    int                      checks = 0;
    int                      cyc = 0;

    cfdt_top #(
        .TICK_CYCLES (TB_TICK)
    ) DUT (
        .SYS_CLK              (clk),
        .RST_N                (rst_n),
        .AXI_REQ              (req),
        .AXI_RSP              (rsp),
        .FAULT_COND           (cond),
        .FAULT                (fault),
        .SHORT_DELAY_DOUBLING (dbl),
        .SENSE_SCALING_SELECT (scl),
        .IRQ                  (irq)
    );

    cfdt_sense_model SENSE (
        .clk   (clk),
        .rst_n (rst_n),
        .trip  (trip),
        .fault (fault),
        .cond  (cond),
        .lag   (lag)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic give_verdict;
        if (fail_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict

    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t value %h expected %h", $time, g, e);
        end
    endtask : chk_word

    // delay tolerance of one tick, none for a zero delay: the tick phase runs free
    task automatic chk_lag(input logic [31:0] g, input int t);
        int e;
        int tol;
        e = t * TB_TICK + 2;
        tol = (t == 0) ? 0 : TB_TICK;
        checks++;
        if ((g >= 32'(e - tol) && g <= 32'(e + tol)) !== 1'b1) begin
            fail_count++;
            $display("[ERR] %0t lag %0d expected %0d", $time, g, e);
        end
    endtask : chk_lag

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] e);
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= d;
        req.wstrb   <= 4'hF;
        while (aw || w) begin
            @(posedge clk);
            if (aw && rsp.awready === 1'b1) begin
                aw = 1'b0;
                req.awvalid <= 1'b0;
            end
            if (w && rsp.wready === 1'b1) begin
                w = 1'b0;
                req.wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (rsp.bvalid !== 1'b1);
        chk_word(32'(rsp.bresp), 32'(e));
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        do @(posedge clk); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        do @(posedge clk); while (rsp.rvalid !== 1'b1);
        chk_word(rsp.rdata, e);
        chk_word(32'(rsp.rresp), 32'(er));
    endtask : rd

    task automatic wait_fault(input logic [3:0] m);
        do @(posedge clk); while ((fault & m) !== m);
        repeat (4) @(posedge clk);
    endtask : wait_fault

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fail_count++;
            give_verdict();
        end
    end

    initial begin
        req = '0;
        req.bready = 1'b1;
        req.rready = 1'b1;
        trip = 4'h0;
        rst_n = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk_word(32'(scl), 32'h1);
        chk_word(32'(dbl), 32'h0);
        chk_word(32'(irq), 32'h0);
        rd(`CFDT_ADDR_CTRL, 32'h2, 2'h0);
        rd(`CFDT_ADDR_DELAY, 32'h0, 2'h0);
        rd(`CFDT_ADDR_MASK, 32'h0, 2'h0);
        rd(`CFDT_ADDR_STATUS, 32'h0, 2'h0);
        rd(`CFDT_ADDR_STEP, 32'h15B8, 2'h0);
        rd(8'h18, 32'h0, 2'h2);
        wr(8'h18, 32'hFFFF, 2'h2);
        // restart: a short trip must not shorten the next delay
        wr(`CFDT_ADDR_DELAY, 32'h1000, 2'h0);
        trip <= 4'h8;
        repeat (200) @(posedge clk);
        chk_word(32'(fault), 32'h0);
        trip <= 4'h0;
        repeat (5) @(posedge clk);
        trip <= 4'h8;
        wait_fault(4'h8);
        chk_lag(lag[3], `CFDT_DSHORT2_STEP_NS / TK);
        chk_word(32'(irq), 32'h0);
        rd(`CFDT_ADDR_STATUS, 32'h8, 2'h0);
        trip <= 4'h0;
        repeat (4) @(posedge clk);
        chk_word(32'(fault), 32'h0);
        rd(`CFDT_ADDR_STATUS, 32'h0, 2'h0);
        // doubled short delays, halved threshold step
        wr(`CFDT_ADDR_CTRL, 32'h1, 2'h0);
        chk_word(32'(dbl), 32'h1);
        chk_word(32'(scl), 32'h0);
        rd(`CFDT_ADDR_STEP, 32'h0ADC, 2'h0);
        wr(`CFDT_ADDR_DELAY, 32'h2100, 2'h0);
        wr(`CFDT_ADDR_MASK, 32'hF, 2'h0);
        trip <= 4'hE;
        wait_fault(4'hE);
        chk_lag(lag[1], 0);
        chk_lag(lag[2], `CFDT_DSHORT1_STEP2_NS / TK);
        chk_lag(lag[3], 2 * (`CFDT_DSHORT2_STEP2_NS / TK));
        chk_word(32'(irq), 32'h1);
        rd(`CFDT_ADDR_STATUS, 32'hE, 2'h0);
        repeat (2) @(posedge clk);
        chk_word(32'(irq), 32'h0);
        trip <= 4'h0;
        // base steps, short timers at their longest settings, overcurrent at its shortest, all timers at once
        wr(`CFDT_ADDR_CTRL, 32'h2, 2'h0);
        wr(`CFDT_ADDR_DELAY, 32'hFFF0, 2'h0);
        trip <= 4'hF;
        wait_fault(4'hF);
        chk_lag(lag[0], `CFDT_DOVC_BASE_NS / TK);
        chk_lag(lag[1], 15 * (`CFDT_CSHORT_STEP_NS / TK));
        chk_lag(lag[2], 15 * (`CFDT_DSHORT1_STEP_NS / TK));
        chk_lag(lag[3], 15 * (`CFDT_DSHORT2_STEP_NS / TK));
        rd(`CFDT_ADDR_STATUS, 32'hF, 2'h0);
        rd(`CFDT_ADDR_FAULT, 32'hF, 2'h0);
        trip <= 4'h0;
        repeat (4) @(posedge clk);
        chk_word(32'(fault), 32'h0);
        give_verdict();
    end
endmodule : cfdt_top_tb
